// ### logic/store_fifo.sv
// write request fifo between address generation and memory port
`timescale 1ns/1ps
module store_fifo #(
    parameter int WIDTH = 96,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic    sys_clk_in,
    input  wire logic    rst_b_in,
    // fill and drain
    store_fifo_if.store  fifo
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("store_fifo depth must be a power of two, at least 2");
        end
        if (WIDTH < 1) begin
            $error("store_fifo width must be positive");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             push;
    logic             pop;

    assign fifo.wready = (cnt_ff < CNT_W'(DEPTH));
    assign fifo.rvalid = (cnt_ff != '0);
    assign fifo.rdata  = mem[rd_ptr_ff];
    assign fifo.level  = cnt_ff;
    assign push        = fifo.wvalid && fifo.wready;
    assign pop         = fifo.rready && fifo.rvalid;

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem[wr_ptr_ff] <= fifo.wdata;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + CNT_W'(push) - CNT_W'(pop);
        end
    end
endmodule

// ### logic/store_fifo_if.sv
// fill and drain signals between the store engine and its fifo
`timescale 1ns/1ps
interface store_fifo_if #(
    parameter int WIDTH = 96,
    parameter int LVL_W = 4
);
    logic [WIDTH-1:0] wdata;
    logic             wvalid;
    logic             wready;
    logic [WIDTH-1:0] rdata;
    logic             rvalid;
    logic             rready;
    logic [LVL_W-1:0] level;

    modport engine (
        output wdata,
        output wvalid,
        output rready,
        input  wready,
        input  rdata,
        input  rvalid,
        input  level
    );

    modport store (
        input  wdata,
        input  wvalid,
        input  rready,
        output wready,
        output rdata,
        output rvalid,
        output level
    );
endinterface

// ### logic/vcap_store_cfg.sv
// capture store address configuration registers and write address engine
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module vcap_store_cfg
    import vcap_store_pkg::*;
#(
    parameter int DATA_W     = 64,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rst_b_in,
    // wishbone slave
    input  wire logic              wb_cyc_in,
    input  wire logic              wb_stb_in,
    input  wire logic              wb_we_in,
    input  wire logic [7:0]        wb_adr_in,
    input  wire logic [3:0]        wb_sel_in,
    input  wire logic [31:0]       wb_dat_in,
    output logic      [31:0]       wb_dat_out,
    output logic                   wb_ack_out,
    // area starts kept by the image address registers
    input  wire logic [31:0]       top_luma_area_start_in,
    input  wire logic [31:0]       bottom_luma_area_start_in,
    input  wire logic [31:0]       top_chroma_area_start_in,
    input  wire logic [31:0]       bottom_chroma_area_start_in,
    // capture stream
    input  wire logic              vid_field_start_in,
    input  wire logic              vid_bottom_in,
    input  wire logic              vid_valid_in,
    input  wire logic [1:0]        vid_kind_in,
    input  wire logic [DATA_W-1:0] vid_data_in,
    output logic                   vid_ready_out,
    // memory controller write port
    output logic                   mem_valid_out,
    output logic      [31:0]       mem_addr_out,
    output logic      [DATA_W-1:0] mem_data_out,
    input  wire logic              mem_ready_in
);
    localparam int STEP   = DATA_W / 8;
    localparam int WORD_W = 32 + DATA_W;
    localparam int LVL_W  = $clog2(FIFO_DEPTH + 1);

    initial begin
        if (DATA_W < 8 || (DATA_W % 8) != 0) begin
            $error("data width must be a whole number of bytes");
        end
        if (FIFO_DEPTH < 2 || FIFO_DEPTH > 255) begin
            $error("fifo depth out of range");
        end
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [31:0] top_vert_anc_start_addr_ff;
    logic [31:0] bottom_vert_anc_start_addr_ff;
    logic [7:0]  subpic_horiz_start_ff;
    logic [8:0]  subpic_width_ff;

    logic        subpic_mode_ff;
    logic        yc_format_ff;

    logic        cur_bottom_ff;

    // bus side
    logic        wb_ack_ff;
    logic [31:0] wb_dat_ff;

    logic        wb_req;
    logic        wb_wr;
    logic [31:0] rd_mux;

    assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_ff;
    assign wb_wr  = wb_req && wb_we_in;

    // merge by byte lane
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return res;
    endfunction

    logic [31:0] subpic_word;
    logic [31:0] subpic_new;
    logic [31:0] ctrl_new;

    always_comb begin
        subpic_word = 32'h0000_0000;
        subpic_word[SP_START_MSB:SP_START_LSB] = subpic_horiz_start_ff;
        subpic_word[SP_WIDTH_MSB:SP_WIDTH_LSB] = subpic_width_ff;
    end

    assign subpic_new = merge(subpic_word, wb_dat_in, wb_sel_in);
    assign ctrl_new   = merge({30'h0, yc_format_ff, subpic_mode_ff}, wb_dat_in, wb_sel_in);

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            top_vert_anc_start_addr_ff    <= ADDR_RST;
            bottom_vert_anc_start_addr_ff <= ADDR_RST;
        end else if (wb_wr) begin
            if (wb_adr_in == TOP_VANC_OFS) begin
                top_vert_anc_start_addr_ff <= merge(top_vert_anc_start_addr_ff, wb_dat_in, wb_sel_in);
            end
            if (wb_adr_in == BOT_VANC_OFS) begin
                bottom_vert_anc_start_addr_ff <= merge(bottom_vert_anc_start_addr_ff, wb_dat_in, wb_sel_in);
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            subpic_horiz_start_ff <= SP_START_RST;
            subpic_width_ff       <= SP_WIDTH_RST;
        end else if (wb_wr && wb_adr_in == SUBPIC_OFS) begin
            subpic_horiz_start_ff <= subpic_new[SP_START_MSB:SP_START_LSB];
            subpic_width_ff       <= subpic_new[SP_WIDTH_MSB:SP_WIDTH_LSB];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            subpic_mode_ff <= CTRL_RST[CTRL_SUBPIC];
            yc_format_ff   <= CTRL_RST[CTRL_YC];
        end else if (wb_wr && wb_adr_in == STORE_CTRL_OFS) begin
            subpic_mode_ff <= ctrl_new[CTRL_SUBPIC];
            yc_format_ff   <= ctrl_new[CTRL_YC];
        end
    end

    // ------------------------------------------------------------
    // register reads and acknowledge
    // ------------------------------------------------------------
    logic [LVL_W-1:0] fifo_level;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_in)
            TOP_VANC_OFS: begin
                rd_mux = top_vert_anc_start_addr_ff;
            end
            BOT_VANC_OFS: begin
                rd_mux = bottom_vert_anc_start_addr_ff;
            end
            SUBPIC_OFS: begin
                rd_mux = subpic_word;
            end
            STORE_CTRL_OFS: begin
                rd_mux = {30'h0, yc_format_ff, subpic_mode_ff};
            end
            STORE_STAT_OFS: begin
                rd_mux[STAT_BOTTOM] = cur_bottom_ff;
                rd_mux[STAT_LVL_LSB +: LVL_W] = fifo_level;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wb_ack_ff <= 1'b0;
        end else begin
            wb_ack_ff <= wb_req;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wb_dat_ff <= 32'h0000_0000;
        end else if (wb_req && !wb_we_in) begin
            wb_dat_ff <= rd_mux;
        end
    end

    assign wb_ack_out = wb_ack_ff;
    assign wb_dat_out = wb_dat_ff;

    // ------------------------------------------------------------
    // per-field snapshot of the layout
    // ------------------------------------------------------------
    logic [31:0] start_lat_ff [KIND_CNT];

    logic [7:0]  hstart_lat_ff;
    logic [8:0]  width_lat_ff;
    logic        subpic_lat_ff;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int k = 0; k < KIND_CNT; k++) begin
                start_lat_ff[k] <= ADDR_RST;
            end
            hstart_lat_ff <= SP_START_RST;
            width_lat_ff  <= SP_WIDTH_RST;
            subpic_lat_ff <= 1'b0;
        end else if (vid_field_start_in) begin
            // bottom start used when vid_bottom_in is set, top start otherwise
            start_lat_ff[KIND_VANC] <= vid_bottom_in ? bottom_vert_anc_start_addr_ff
                                                     : top_vert_anc_start_addr_ff;
            start_lat_ff[KIND_LUMA] <= vid_bottom_in ? bottom_luma_area_start_in
                                                     : top_luma_area_start_in;
            start_lat_ff[KIND_CHROMA] <= vid_bottom_in ? bottom_chroma_area_start_in
                                                       : top_chroma_area_start_in;
            hstart_lat_ff <= subpic_horiz_start_ff;
            width_lat_ff  <= subpic_width_ff;
            subpic_lat_ff <= subpic_mode_ff && yc_format_ff;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cur_bottom_ff <= 1'b0;
        end else if (vid_field_start_in) begin
            cur_bottom_ff <= vid_bottom_in;
        end
    end

    // ------------------------------------------------------------
    // address generation per data kind
    // ------------------------------------------------------------
    store_fifo_if #(.WIDTH(WORD_W), .LVL_W(LVL_W)) fifo_bus ();

    logic        vid_ready_ff;
    logic        take;
    logic [1:0]  kind;

    logic [31:0] col_ff  [KIND_CNT];
    logic [31:0] base_ff [KIND_CNT];

    logic [31:0] col_next;
    logic        use_subpic;
    logic [31:0] wr_addr;

    assign kind       = (vid_kind_in < 2'(KIND_CNT)) ? vid_kind_in : 2'(KIND_VANC);
    assign take       = vid_valid_in && vid_ready_ff && !vid_field_start_in
                        && (vid_kind_in != KIND_NONE);
    assign use_subpic = subpic_lat_ff && (kind != KIND_VANC);
    assign col_next   = col_ff[kind] + 32'(STEP);
    assign wr_addr    = start_lat_ff[kind] + base_ff[kind] + col_ff[kind];

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int k = 0; k < KIND_CNT; k++) begin
                col_ff[k]  <= 32'h0000_0000;
                base_ff[k] <= 32'h0000_0000;
            end
        end else if (vid_field_start_in) begin
            for (int k = 0; k < KIND_CNT; k++) begin
                // sub-picture rows open at the horizontal start
                if (subpic_mode_ff && yc_format_ff && k != KIND_VANC) begin
                    col_ff[k] <= {24'h0, subpic_horiz_start_ff};
                end else begin
                    col_ff[k] <= 32'h0000_0000;
                end
                base_ff[k] <= 32'h0000_0000;
            end
        end else if (take) begin
            // row full: back to hstart, next row
            if (use_subpic && col_next >= {23'h0, width_lat_ff}) begin
                col_ff[kind]  <= {24'h0, hstart_lat_ff};
                base_ff[kind] <= base_ff[kind] + {23'h0, width_lat_ff};
            end else begin
                col_ff[kind] <= col_next;
            end
        end
    end

    assign fifo_bus.wdata  = {wr_addr, vid_data_in};
    assign fifo_bus.wvalid = take;

    // ready only while two slots remain, since ready lags by one cycle
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            vid_ready_ff <= 1'b0;
        end else begin
            vid_ready_ff <= (fifo_bus.level + LVL_W'(take)) <= LVL_W'(FIFO_DEPTH - 2);
        end
    end

    assign vid_ready_out = vid_ready_ff;
    assign fifo_level    = fifo_bus.level;

    store_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .fifo       (fifo_bus.store)
    );

    // ------------------------------------------------------------
    // memory write port output stage
    // ------------------------------------------------------------
    logic              mem_valid_ff;
    logic [31:0]       mem_addr_ff;
    logic [DATA_W-1:0] mem_data_ff;

    logic              out_load;

    // refill when empty or taken
    assign out_load       = !mem_valid_ff || mem_ready_in;
    assign fifo_bus.rready = out_load;

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mem_valid_ff <= 1'b0;
            mem_addr_ff  <= 32'h0000_0000;
            mem_data_ff  <= '0;
        end else if (out_load) begin
            mem_valid_ff <= fifo_bus.rvalid;
            if (fifo_bus.rvalid) begin
                mem_addr_ff <= fifo_bus.rdata[WORD_W-1 -: 32];
                mem_data_ff <= fifo_bus.rdata[DATA_W-1:0];
            end
        end
    end

    assign mem_valid_out = mem_valid_ff;
    assign mem_addr_out  = mem_addr_ff;
    assign mem_data_out  = mem_data_ff;

endmodule

// ### logic/vcap_store_pkg.sv
// constants for the capture store address configuration block
package vcap_store_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses on the bus)
    // ------------------------------------------------------------
    localparam logic [7:0] TOP_VANC_OFS   = 8'h00;
    localparam logic [7:0] BOT_VANC_OFS   = 8'h04;
    localparam logic [7:0] SUBPIC_OFS     = 8'h08;
    localparam logic [7:0] STORE_CTRL_OFS = 8'h0c;
    localparam logic [7:0] STORE_STAT_OFS = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SP_START_LSB = 16;
    localparam int SP_START_MSB = 23;
    localparam int SP_WIDTH_LSB = 0;
    localparam int SP_WIDTH_MSB = 8;
    localparam int CTRL_SUBPIC  = 0;
    localparam int CTRL_YC      = 1;
    localparam int STAT_BOTTOM  = 0;
    localparam int STAT_LVL_LSB = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
    localparam logic [7:0]  SP_START_RST  = 8'h00;
    localparam logic [8:0]  SP_WIDTH_RST  = 9'h010;
    localparam logic [1:0]  CTRL_RST      = 2'h0;

    // ------------------------------------------------------------
    // data kinds on the capture stream
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_VANC,
        KIND_LUMA,
        KIND_CHROMA,
        KIND_NONE
    } data_kind_type;

    localparam int KIND_CNT = 3;
    localparam int FIFO_DEPTH_DEF = 8;

endpackage

// ### sim/mem_write_model.sv
// memory controller write port model with optional stalls
`timescale 1ns/1ps
module mem_write_model (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    // write port
    input  wire logic        mem_valid_in,
    input  wire logic [31:0] mem_addr_in,
    input  wire logic [63:0] mem_data_in,
    input  wire logic        slow_in,
    output logic             mem_ready_out
);
    logic [31:0] addr_q[$];
    logic [63:0] data_q[$];
    logic [2:0]  tick_ff;
    // slow mode takes one word in eight cycles
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tick_ff       <= 3'h0;
            mem_ready_out <= 1'b0;
        end else begin
            tick_ff       <= tick_ff + 3'h1;
            mem_ready_out <= !slow_in || tick_ff == 3'h7;
            if (mem_valid_in && mem_ready_out) begin
                addr_q.push_back(mem_addr_in);
                data_q.push_back(mem_data_in);
            end
        end
    end
endmodule

// ### sim/tb_vcap_store_cfg.sv
// self-checking bench for the capture store configuration block
`timescale 1ns/1ps
module tb_vcap_store_cfg
    import vcap_store_pkg::*;
;
    typedef struct {
        logic [7:0]  adr;
        logic [31:0] wd;
        logic [3:0]  sel;
        logic [31:0] rd;
    } row_type;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        sys_clk_in = 1'b0;
    logic        rst_b_in   = 1'b0;
    logic        wb_cyc     = 1'b0;
    logic        wb_stb     = 1'b0;
    logic        wb_we      = 1'b0;
    logic [7:0]  wb_adr     = 8'h00;
    logic [3:0]  wb_sel     = 4'h0;
    logic [31:0] wb_wd      = 32'h0;
    logic [31:0] wb_rd;
    logic        wb_ack;
    logic [31:0] ty_start   = 32'h3000_0000;
    logic        fld        = 1'b0;
    logic        bot        = 1'b0;
    logic        vld        = 1'b0;
    logic [1:0]  kind       = 2'h0;
    logic [63:0] vdat       = 64'h0;
    logic        vrdy;
    logic        slow       = 1'b0;
    logic        saw_stall  = 1'b0;
    logic        m_valid;
    logic        m_ready;
    logic [31:0] m_addr;
    logic [63:0] m_data;
    logic [31:0] q;
    int          err_total  = 0;
    int          cmp_count  = 0;
    row_type     rows [7];
    always #12.5 sys_clk_in = ~sys_clk_in;
    vcap_store_cfg #(.DATA_W(64), .FIFO_DEPTH(8)) dut (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wd),
        .wb_dat_out(wb_rd), .wb_ack_out(wb_ack), .top_luma_area_start_in(ty_start),
        .bottom_luma_area_start_in(32'h5000_0000), .top_chroma_area_start_in(32'h4000_0000),
        .bottom_chroma_area_start_in(32'h6000_0000), .vid_field_start_in(fld), .vid_bottom_in(bot),
        .vid_valid_in(vld), .vid_kind_in(kind), .vid_data_in(vdat), .vid_ready_out(vrdy),
        .mem_valid_out(m_valid), .mem_addr_out(m_addr), .mem_data_out(m_data), .mem_ready_in(m_ready));
    mem_write_model mem (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .mem_valid_in(m_valid),
        .mem_addr_in(m_addr), .mem_data_in(m_data), .slow_in(slow), .mem_ready_out(m_ready));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_up(input string nm);
        err_total++;
        $display("FAIL %s expected done seen timeout", nm);
        stop_test();
    endtask
    task automatic wb_op(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_wd  <= d;
        wb_sel <= s;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (wb_ack !== 1'b1 && n < 16);
        if (wb_ack !== 1'b1) give_up("wb_ack");
        q = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_op(1'b1, a, d, 4'hf);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb_op(1'b0, a, 32'h0, 4'hf);
        chk("reg", {32'h0, e}, {32'h0, q});
    endtask
    // a word offered with the field start must be dropped
    task automatic field(input logic b);
        @(posedge sys_clk_in);
        fld  <= 1'b1;
        bot  <= b;
        vld  <= 1'b1;
        kind <= 2'h0;
        vdat <= 64'hdead;
        @(posedge sys_clk_in);
        fld <= 1'b0;
        vld <= 1'b0;
    endtask
    task automatic word(input logic [1:0] k, input logic [63:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        vld  <= 1'b1;
        kind <= k;
        vdat <= d;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (vrdy !== 1'b1 && n < 200);
        if (n > 1) saw_stall = 1'b1;
        if (vrdy !== 1'b1) give_up("vid_ready");
        vld <= 1'b0;
    endtask
    task automatic pop_chk(input logic [31:0] a, input logic [63:0] d);
        int n;
        for (n = 0; n < 200 && mem.addr_q.size() == 0; n++) @(posedge sys_clk_in);
        if (n >= 200) give_up("mem write");
        chk("mem_addr", {32'h0, a}, {32'h0, mem.addr_q.pop_front()});
        chk("mem_data", d, mem.data_q.pop_front());
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        int i;
        rows[0] = '{TOP_VANC_OFS, 32'h1000_0008, 4'hf, 32'h1000_0008};
        rows[1] = '{BOT_VANC_OFS, 32'h2000_0010, 4'hf, 32'h2000_0010};
        rows[2] = '{SUBPIC_OFS, 32'hff08_fe20, 4'hf, 32'h0008_0020};
        rows[3] = '{SUBPIC_OFS, 32'h0010_0040, 4'hf, 32'h0010_0040};
        rows[4] = '{TOP_VANC_OFS, 32'h0000_00f8, 4'h1, 32'h1000_00f8};
        rows[5] = '{8'h14, 32'hffff_ffff, 4'hf, 32'h0000_0000};
        rows[6] = '{STORE_CTRL_OFS, 32'h0000_0003, 4'hf, 32'h0000_0003};
        repeat (3) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        for (i = 0; i < 7; i++) begin
            wb_op(1'b1, rows[i].adr, rows[i].wd, rows[i].sel);
            rd_chk(rows[i].adr, rows[i].rd);
        end
        @(posedge sys_clk_in);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        rd_chk(TOP_VANC_OFS, ADDR_RST);
        rd_chk(BOT_VANC_OFS, ADDR_RST);
        rd_chk(SUBPIC_OFS, {8'h00, SP_START_RST, 7'h00, SP_WIDTH_RST});
        rd_chk(STORE_CTRL_OFS, {30'h0, CTRL_RST});
        wr(TOP_VANC_OFS, 32'h1000_0000);
        wr(BOT_VANC_OFS, 32'h2000_0000);
        field(1'b0);
        for (i = 0; i < 3; i++) word(2'h0, 64'ha0 + i);
        wr(TOP_VANC_OFS, 32'h1800_0000);
        word(2'h3, 64'hbad);
        word(2'h0, 64'ha3);
        for (i = 0; i < 4; i++) pop_chk(32'h1000_0000 + 8 * i, 64'ha0 + i);
        field(1'b1);
        for (i = 0; i < 2; i++) word(2'h0, 64'hb0 + i);
        for (i = 0; i < 2; i++) pop_chk(32'h2000_0000 + 8 * i, 64'hb0 + i);
        rd_chk(STORE_STAT_OFS, 32'h0000_0001);
        field(1'b0);
        word(2'h0, 64'hc0);
        pop_chk(32'h1800_0000, 64'hc0);
        wr(SUBPIC_OFS, 32'h0008_0020);
        wr(STORE_CTRL_OFS, 32'h0000_0003);
        field(1'b0);
        ty_start <= 32'h3800_0000;
        for (i = 0; i < 4; i++) word(2'h1, 64'hd0 + i);
        word(2'h2, 64'he0);
        word(2'h0, 64'he1);
        pop_chk(32'h3000_0008, 64'hd0);
        pop_chk(32'h3000_0010, 64'hd1);
        pop_chk(32'h3000_0018, 64'hd2);
        pop_chk(32'h3000_0028, 64'hd3);
        pop_chk(32'h4000_0008, 64'he0);
        pop_chk(32'h1800_0000, 64'he1);
        field(1'b1);
        word(2'h2, 64'hf0);
        pop_chk(32'h6000_0008, 64'hf0);
        wr(STORE_CTRL_OFS, 32'h0000_0001);
        field(1'b0);
        word(2'h1, 64'hf1);
        pop_chk(32'h3800_0000, 64'hf1);
        wr(STORE_CTRL_OFS, 32'h0000_0000);
        slow <= 1'b1;
        field(1'b0);
        for (i = 0; i < 16; i++) word(2'h0, 64'h100 + i);
        chk("stall", 64'h1, {63'h0, saw_stall});
        for (i = 0; i < 16; i++) pop_chk(32'h1800_0000 + 8 * i, 64'h100 + i);
        repeat (4) @(posedge sys_clk_in);
        chk("mem_valid", 64'h0, {63'h0, m_valid});
        stop_test();
    end
endmodule

// ### sim/vcap_store_cfg_monitor.sv
// port assertions for the capture store configuration block
`timescale 1ns/1ps
module vcap_store_cfg_monitor
    import vcap_store_pkg::*;
#(
    parameter int DATA_W     = 64,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic              sys_clk_in,
    input wire logic              rst_b_in,
    // register bus
    input wire logic              wb_cyc_in,
    input wire logic              wb_stb_in,
    input wire logic              wb_we_in,
    input wire logic [7:0]        wb_adr_in,
    input wire logic [31:0]       wb_dat_out,
    input wire logic              wb_ack_out,
    // stream and memory port
    input wire logic              vid_field_start_in,
    input wire logic              vid_valid_in,
    input wire logic [1:0]        vid_kind_in,
    input wire logic              vid_ready_out,
    input wire logic              mem_valid_out,
    input wire logic [31:0]       mem_addr_out,
    input wire logic [DATA_W-1:0] mem_data_out,
    input wire logic              mem_ready_in
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic [7:0] pend_ff;
    logic       took;
    logic       given;
    assign took  = vid_valid_in & vid_ready_out & ~vid_field_start_in & (vid_kind_in != 2'h3);
    assign given = mem_valid_out & mem_ready_in;
    // words accepted but not yet handed to memory
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pend_ff <= 8'h00;
        end else begin
            pend_ff <= pend_ff + {7'h00, took} - {7'h00, given};
        end
    end
    sequence bus_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence bus_read;
        wb_ack_out && !wb_we_in;
    endsequence
    sequence mem_wait;
        mem_valid_out && !mem_ready_in;
    endsequence
    ack_after_req_a: assert property (bus_req |=> wb_ack_out) else $error("ack missing after request");
    ack_one_cycle_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
    ack_needs_req_a: assert property (wb_ack_out |-> $past(wb_stb_in)) else $error("ack without request");
    cfg_reserved_zero_a: assert property (bus_read and wb_adr_in == SUBPIC_OFS |->
        wb_dat_out[31:24] == 8'h00 && wb_dat_out[15:9] == 7'h00) else $error("reserved bits not zero");
    unmapped_zero_a: assert property (bus_read and wb_adr_in > STORE_STAT_OFS |-> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    mem_hold_a: assert property (mem_wait |=> mem_valid_out && $stable(mem_addr_out) && $stable(mem_data_out))
        else $error("memory request changed while waiting");
    mem_has_word_a: assert property (mem_valid_out |-> pend_ff != 8'h00) else $error("memory write without word");
    pend_bound_a: assert property (pend_ff <= FIFO_DEPTH + 2) else $error("stream accepted beyond buffer");
    ready_release_a: assert property ($rose(rst_b_in) |=> vid_ready_out) else $error("stream not ready after reset");
endmodule

bind vcap_store_cfg vcap_store_cfg_monitor #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) mon (.*);
